// ===== dv/tmsc_light_drv_model.sv
// illumination driver stand-in on the far side of the light drive pair
// assumes the drive pins and trim arrive on the block's own clock
`timescale 1ns/100ps
module tmsc_light_drv_model (
  input  wire logic       clock,
  input  wire logic       srst,
  input  wire logic       drv_true,
  input  wire logic       drv_comp,
  input  wire logic [3:0] trim_steps,
  output logic            fault
);
  // a pair that is not complementary would short the bridge, so it is latched
  always_ff @(posedge clock) begin
    if (srst) begin
      fault <= 1'b0;
    end else if (drv_comp == drv_true || trim_steps > 4'hB) begin
      fault <= 1'b1;
    end
  end
endmodule : tmsc_light_drv_model

// ===== dv/tmsc_mod_shutter_tb.sv
// self-checking bench of the modulation and shutter control block
// assumes tmsc_pkg is compiled first; the lead count is shortened for speed
`timescale 1ns/100ps
module tmsc_mod_shutter_tb;
  import tmsc_pkg::*;
  localparam int LEAD = 5;
  typedef struct packed {
    logic       sh, tr, cp, dm, act;
    logic [1:0] eq;
    logic       dir;
    logic [3:0] st;
    tmsc_pll_t  pll;
  } tmsc_exp_t;
  logic       clock = 1'b0, srst = 1'b1, odd = 1'b0, fsel = 1'b0, apply = 1'b0, chk = 1'b0;
  logic       sh, tr, cp, dm, act, dir, fault;
  logic [1:0] qn = 2'h0, eq;
  logic [3:0] st;
  logic [15:0] cd = 16'h0000;
  tmsc_quad_t quad = TMSC_Q_DEAD;
  tmsc_cfg_t  cfg = '0;
  tmsc_hop_t  hb = '0, hd = '0;
  tmsc_pll_t  staged = '0, pll, pll_exp = {8'h10, 16'h0000, 4'h1, 4'h1};
  tmsc_exp_t  q[$];
  int         n_mismatch = 0, n_compared = 0, cycles = 0, nt, nd;
  int         diff_tab[4] = '{0, 8, 16, 8};

  tmsc_mod_shutter #(.LEAD_CYC(LEAD)) DUT (.clock(clock), .srst(srst), .quad_state(quad),
    .quad_number(qn), .sub_frame_odd(odd), .dealias_freq_sel(fsel), .intg_countdown(cd),
    .cfg(cfg), .hop_base(hb), .hop_dealias(hd), .pll_staged(staged),
    .pll_apply_pulse(apply), .shutter_closed(sh), .light_drive_true(tr),
    .light_drive_comp(cp), .pixel_demod(dm), .light_driver_active(act), .eff_quad(eq),
    .duty_trim_direction(dir), .duty_trim_steps(st), .pll_applied(pll));
  tmsc_light_drv_model partner (.clock(clock), .srst(srst), .drv_true(tr), .drv_comp(cp),
    .trim_steps(st), .fault(fault));

  // clock and hang guard; the ceiling is well above the few hundred cycles needed
  always #25 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 6000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  task automatic check(input logic [43:0] got, input logic [43:0] want);
    n_compared++;
    if (got !== want) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got %h want %h", $time, got, want);
    end
  endtask : check

  // expected outputs for held inputs; integration is only judged here with hold on
  function automatic tmsc_exp_t model();
    tmsc_hop_t h;
    tmsc_exp_t e;
    h = fsel ? hd : hb;
    e.sh = (quad == TMSC_Q_READOUT || quad == TMSC_Q_DEAD) ? !cfg.shutter_en : 1'b1;
    e.tr = (quad == TMSC_Q_INTEG) ? cfg.light_dc_level : 1'b0;
    e.cp = !e.tr;
    e.dm = (quad == TMSC_Q_INTEG) ? cfg.pixel_dc_level : 1'b0;
    e.act = quad == TMSC_Q_INTEG || (cd != 0 && cd <= (cfg.light_driver_lead ? LEAD : 1));
    e.eq = qn + ((h.hop_en && odd) ? h.hop_offset : 2'h0);
    e.dir = cfg.duty_trim_direction;
    e.st = (cfg.duty_trim_steps > 4'hB) ? 4'hB : cfg.duty_trim_steps;
    e.pll = pll_exp;
    return e;
  endfunction : model

  // let inputs settle, then note the expectation for the monitor
  task automatic settle();
    repeat (4) @(negedge clock);
    q.push_back(model());
    chk = 1'b1;
    @(negedge clock);
    chk = 1'b0;
  endtask : settle

  // count drive changes and disagreements with the pixel waveform over 16 cycles
  task automatic measure(output int n_t, output int n_d);
    logic prev;
    n_t = 0;
    n_d = 0;
    repeat (3) @(negedge clock);
    prev = tr;
    repeat (16) begin
      @(negedge clock);
      n_t += int'(tr != prev);
      n_d += int'(tr != dm);
      prev = tr;
    end
  endtask : measure

  // monitor: oldest note against what the outputs show
  always @(posedge clock) begin
    if (chk) check({sh, tr, cp, dm, act, eq, dir, st, pll}, q.pop_front());
  end

  task automatic end_of_test();
    check(44'(fault), 44'h0);
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test

  initial begin
    void'($urandom(32'hAF07F44C));
    repeat (10) @(negedge clock);
    srst = 1'b0;
    settle();
    $display("reset values done");
    cfg.mod_hold = 1'b1;
    for (int en = 0; en < 2; en++) begin
      for (int s = 0; s < 4; s++) begin
        cfg.shutter_en = 1'(en);
        {cfg.light_dc_level, cfg.pixel_dc_level} = 2'($urandom);
        quad = tmsc_quad_t'(4'h1 << s);
        settle();
      end
    end
    $display("shutter table done");
    quad = TMSC_Q_DEAD;
    repeat (16) begin
      {qn, odd, fsel, hb, hd} = 10'($urandom);
      {cfg.duty_trim_direction, cfg.duty_trim_steps} = 5'($urandom);
      settle();
    end
    $display("hop and trim done");
    {qn, odd, hb, hd} = '0;
    for (int ld = 0; ld < 2; ld++) begin
      cfg.light_driver_lead = 1'(ld);
      foreach (diff_tab[i]) begin
        cd = (i < 2) ? 16'(LEAD + 1 - i) : 16'(4 - i);
        settle();
      end
    end
    cd = 16'h0000;
    $display("driver enable done");
    staged = {8'h14, 16'($urandom), 4'h1, 4'h0};
    cfg.mod_hold = 1'b0;
    quad = TMSC_Q_INTEG;
    measure(nt, nd);
    check(44'(nt), 44'd4);
    check(44'(nd), 44'd0);
    quad = TMSC_Q_DEAD;
    apply = 1'b1;
    settle();
    apply = 1'b0;
    pll_exp = staged;
    settle();
    quad = TMSC_Q_INTEG;
    foreach (diff_tab[i]) begin
      qn = 2'(i);
      measure(nt, nd);
      check(44'(nt), 44'd8);
      check(44'(nd), 44'(diff_tab[i]));
    end
    $display("modulation and pll done");
    end_of_test();
  end
endmodule : tmsc_mod_shutter_tb

// ===== hdl/tmsc_map.svh
// constants of the modulation and shutter control block: reset values and timing counts
// assumes a 20 MHz system clock and four quads per modulation frequency
`ifndef TMSC_MAP_SVH
`define TMSC_MAP_SVH

`define TMSC_CLK_NS        50
`define TMSC_LEAD_NS       15000
`define TMSC_LEAD_CYC      ((`TMSC_LEAD_NS + `TMSC_CLK_NS - 1) / `TMSC_CLK_NS)
`define TMSC_QUADS         4
`define TMSC_TRIM_MAX      4'hB
`define TMSC_MULT_RST      8'h10
`define TMSC_FRAC_RST      16'h0000
`define TMSC_DIV_RST       4'h1
`define TMSC_PS_RST        4'h1
`define TMSC_SHUTTER_RST   1'b0
`define TMSC_HOLD_RST      1'b0
`define TMSC_LEAD_RST      1'b0

`endif

// ===== hdl/tmsc_mod_shutter.sv
// modulation and shutter control: shutter switch, light drive pair, driver enable,
// per-quad phase stepping and the staged modulation pll settings.
// assumes the timing generator supplies quad state, quad number, sub-frame parity
// and a countdown to the next integration start, all synchronous to clock.
`timescale 1ns/100ps
`include "tmsc_map.svh"

// Summary of operation
// - shutter enabled: switch closed in reset and integration, open in readout and dead time
// - shutter disabled: switch closed in every quad state
// - shutter enable resets to 0; writing 1 turns shutter operation on
// - illumination to demodulation phase steps automatically with each quad
// - quad hopping on gives odd sub-frames a different sequence than even ones
// - effective quad is quad plus hop offset; phase is 360 times it over quad count
// - base and de-aliasing frequencies each keep their own phase sequence settings
// - true light output toggles only in integration, low otherwise
// - complement light output toggles only in integration, high otherwise
// - driver enable rises just before integration and falls just after it
// - lead setting 1 raises driver enable 15 us before integration; default 0
// - modulation hold 1 suppresses modulation during integration; default 0
// - during hold, true output equals static level and complement its inverse
// - trim direction 0 increases true output duty cycle, 1 reduces it
// - trim is a step count of about 450 ps, at most 0Bh
// - base frequency is multiplier times 24 MHz over divider, quad count, prescaler
// - effective multiplier is integer part plus fraction over 2 to the 16
// - pll settings reset to multiplier 16, fraction 0, divider 1, prescaler 1
module tmsc_mod_shutter
  import tmsc_pkg::*;
#(
  parameter int QUADS    = `TMSC_QUADS,
  parameter int LEAD_CYC = `TMSC_LEAD_CYC
) (
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire tmsc_quad_t  quad_state,
  input  wire logic [1:0]  quad_number,
  input  wire logic        sub_frame_odd,
  input  wire logic        dealias_freq_sel,
  input  wire logic [15:0] intg_countdown,
  input  wire tmsc_cfg_t   cfg,
  input  wire tmsc_hop_t   hop_base,
  input  wire tmsc_hop_t   hop_dealias,
  input  wire tmsc_pll_t   pll_staged,
  input  wire logic        pll_apply_pulse,
  output logic             shutter_closed,
  output logic             light_drive_true,
  output logic             light_drive_comp,
  output logic             pixel_demod,
  output logic             light_driver_active,
  output logic [1:0]       eff_quad,
  output logic             duty_trim_direction,
  output logic [3:0]       duty_trim_steps,
  output tmsc_pll_t        pll_applied
);

  localparam tmsc_cfg_t CFG_RST = '{shutter_en: `TMSC_SHUTTER_RST, mod_hold: `TMSC_HOLD_RST,
                                    pixel_dc_level: 1'b0, light_dc_level: 1'b0,
                                    light_driver_lead: `TMSC_LEAD_RST,
                                    duty_trim_direction: 1'b0, duty_trim_steps: 4'h0};
  localparam tmsc_pll_t PLL_RST = '{pll_multiplier: `TMSC_MULT_RST,
                                    pll_multiplier_fraction: `TMSC_FRAC_RST,
                                    pll_divider: `TMSC_DIV_RST, pll_prescaler: `TMSC_PS_RST};
  localparam logic [15:0] LEAD_LIM = 16'(LEAD_CYC);
  localparam logic [1:0]  HALF_Q   = 2'(QUADS / 2);

  tmsc_cfg_t   cfg_reg;
  tmsc_pll_t   pll_reg;
  logic        apply_d_reg;
  logic [3:0]  div_reg;
  logic        tick;
  logic [1:0]  mod_cnt_reg;
  logic [1:0]  eff_next;
  logic [1:0]  light_phase;
  tmsc_hop_t   hop_sel;
  logic        integ_now;
  logic        integ_d_reg;
  logic        lead_hit;
  logic        shutter_reg;
  logic        true_reg;
  logic        comp_reg;
  logic        demod_reg;
  logic        active_reg;
  logic [1:0]  eff_reg;
  logic        trim_dir_reg;
  logic [3:0]  trim_reg;

  // configuration capture; a single stage keeps mid-quad changes glitch free
  always_ff @(posedge clock) begin
    if (srst) begin
      cfg_reg <= CFG_RST;
    end else begin
      cfg_reg <= cfg;
    end
  end

  // pll settings take effect on the falling edge of the update bit, i.e. after 1 then 0
  always_ff @(posedge clock) begin
    if (srst) begin
      pll_reg     <= PLL_RST;
      apply_d_reg <= 1'b0;
    end else begin
      apply_d_reg <= pll_apply_pulse;
      if (apply_d_reg && !pll_apply_pulse) begin
        pll_reg <= pll_staged;
      end
    end
  end

  // the analog pll is outside; this prescaled tick stands for one oscillator step
  // so the quad counter below spans quad count times (1 + prescaler) clock cycles
  // compare with >= so a smaller prescaler applied mid-count cannot stall the divider
  assign tick = (div_reg >= pll_reg.pll_prescaler);

  always_ff @(posedge clock) begin
    if (srst) begin
      div_reg     <= 4'h0;
      mod_cnt_reg <= 2'h0;
    end else if (tick) begin
      div_reg     <= 4'h0;
      mod_cnt_reg <= (mod_cnt_reg == 2'(QUADS - 1)) ? 2'h0 : mod_cnt_reg + 2'h1;
    end else begin
      div_reg <= div_reg + 4'h1;
    end
  end

  // per-frequency hop settings; the offset only applies on odd sub-frames
  always_comb begin
    hop_sel  = dealias_freq_sel ? hop_dealias : hop_base;
    eff_next = quad_number;
    if (hop_sel.hop_en && sub_frame_odd) begin
      eff_next = quad_number + hop_sel.hop_offset;
    end
    light_phase = mod_cnt_reg + eff_next;
  end

  assign integ_now = (quad_state == TMSC_Q_INTEG);

  // lead window: either 15 us early, or a single cycle early when lead is off
  assign lead_hit = (intg_countdown != 16'h0) &&
                    (intg_countdown <= (cfg_reg.light_driver_lead ? LEAD_LIM : 16'h1));

  // shutter switch
  always_ff @(posedge clock) begin
    if (srst) begin
      shutter_reg <= 1'b1;
    end else begin
      case (quad_state)
        TMSC_Q_RESET:   shutter_reg <= 1'b1;
        TMSC_Q_INTEG:   shutter_reg <= 1'b1;
        TMSC_Q_READOUT: shutter_reg <= !cfg_reg.shutter_en;
        TMSC_Q_DEAD:    shutter_reg <= !cfg_reg.shutter_en;
        default:        shutter_reg <= 1'b1;
      endcase
    end
  end

  // light drive pair and pixel demodulation
  always_ff @(posedge clock) begin
    if (srst) begin
      true_reg  <= 1'b0;
      comp_reg  <= 1'b1;
      demod_reg <= 1'b0;
    end else if (!integ_now) begin
      true_reg  <= 1'b0;
      comp_reg  <= 1'b1;
      demod_reg <= 1'b0;
    end else if (cfg_reg.mod_hold) begin
      true_reg  <= cfg_reg.light_dc_level;
      comp_reg  <= !cfg_reg.light_dc_level;
      demod_reg <= cfg_reg.pixel_dc_level;
    end else begin
      true_reg  <= (light_phase < HALF_Q);
      comp_reg  <= !(light_phase < HALF_Q);
      demod_reg <= (mod_cnt_reg < HALF_Q);
    end
  end

  // driver enable stays up one extra cycle after integration ends
  always_ff @(posedge clock) begin
    if (srst) begin
      integ_d_reg <= 1'b0;
      active_reg  <= 1'b0;
    end else begin
      integ_d_reg <= integ_now;
      active_reg  <= integ_now || integ_d_reg || lead_hit;
    end
  end

  // effective quad and duty trim to the analog side; trim clamped to its maximum
  always_ff @(posedge clock) begin
    if (srst) begin
      eff_reg      <= 2'h0;
      trim_dir_reg <= 1'b0;
      trim_reg     <= 4'h0;
    end else begin
      eff_reg      <= eff_next;
      trim_dir_reg <= cfg_reg.duty_trim_direction;
      trim_reg     <= (cfg_reg.duty_trim_steps > `TMSC_TRIM_MAX) ?
                      `TMSC_TRIM_MAX : cfg_reg.duty_trim_steps;
    end
  end

  assign shutter_closed      = shutter_reg;
  assign light_drive_true    = true_reg;
  assign light_drive_comp    = comp_reg;
  assign pixel_demod         = demod_reg;
  assign light_driver_active = active_reg;
  assign eff_quad            = eff_reg;
  assign duty_trim_direction = trim_dir_reg;
  assign duty_trim_steps     = trim_reg;
  assign pll_applied         = pll_reg;

  property p_shutter_open;
    @(posedge clock) disable iff (srst)
      (cfg_reg.shutter_en && quad_state == TMSC_Q_READOUT) |=> !shutter_closed;
  endproperty
  a_shutter_open: assert property (p_shutter_open) else $error("shutter not open");

  property p_shutter_off;
    @(posedge clock) disable iff (srst)
      (!cfg_reg.shutter_en) |=> shutter_closed;
  endproperty
  a_shutter_off: assert property (p_shutter_off) else $error("shutter opened");

  property p_shutter_rst;
    @(posedge clock) $fell(srst) |-> !cfg_reg.shutter_en;
  endproperty
  a_shutter_rst: assert property (p_shutter_rst) else $error("shutter enable reset");

  property p_step;
    @(posedge clock) disable iff (srst)
      tick |=> (mod_cnt_reg == (($past(mod_cnt_reg) == 2'(QUADS - 1)) ? 2'h0 :
                                $past(mod_cnt_reg) + 2'h1));
  endproperty
  a_step: assert property (p_step) else $error("phase counter step wrong");

  property p_nohop;
    @(posedge clock) disable iff (srst)
      (!hop_base.hop_en && !dealias_freq_sel) |=> (eff_quad == $past(quad_number));
  endproperty
  a_nohop: assert property (p_nohop) else $error("quad offset without hopping");

  property p_idle_true;
    @(posedge clock) disable iff (srst)
      (!integ_now) |=> (!light_drive_true && light_drive_comp);
  endproperty
  a_idle_true: assert property (p_idle_true) else $error("light pair not idle");

  property p_hold;
    @(posedge clock) disable iff (srst)
      (integ_now && cfg_reg.mod_hold) |=>
        (light_drive_true == $past(cfg_reg.light_dc_level)) &&
        (light_drive_comp != light_drive_true);
  endproperty
  a_hold: assert property (p_hold) else $error("hold level wrong");

  property p_active_end;
    @(posedge clock) disable iff (srst)
      (integ_now ##1 (!integ_now && !lead_hit)[*2]) |=> !light_driver_active;
  endproperty
  a_active_end: assert property (p_active_end) else $error("enable late to drop");

  property p_lead;
    @(posedge clock) disable iff (srst)
      (cfg_reg.light_driver_lead && intg_countdown == LEAD_LIM) |=> light_driver_active;
  endproperty
  a_lead: assert property (p_lead) else $error("early enable missing");

  property p_trim;
    @(posedge clock) disable iff (srst) duty_trim_steps <= `TMSC_TRIM_MAX;
  endproperty
  a_trim: assert property (p_trim) else $error("trim above maximum");

  property p_pll_rst;
    @(posedge clock) $fell(srst) |-> (pll_applied == PLL_RST);
  endproperty
  a_pll_rst: assert property (p_pll_rst) else $error("pll reset values");

  property p_pll_keep;
    @(posedge clock) disable iff (srst)
      !(apply_d_reg && !pll_apply_pulse) |=> $stable(pll_applied);
  endproperty
  a_pll_keep: assert property (p_pll_keep) else $error("pll changed early");

  property p_shut_integ;
    @(posedge clock) disable iff (srst)
      (quad_state == TMSC_Q_RESET || quad_state == TMSC_Q_INTEG) |=> shutter_closed;
  endproperty
  a_shut_integ: assert property (p_shut_integ) else $error("shutter not closed");

  property p_demod_hold;
    @(posedge clock) disable iff (srst)
      (integ_now && cfg_reg.mod_hold) |=> (pixel_demod == $past(cfg_reg.pixel_dc_level));
  endproperty
  a_demod_hold: assert property (p_demod_hold) else $error("demod hold level");

  property p_hop_alt;
    @(posedge clock) disable iff (srst)
      (dealias_freq_sel && hop_dealias.hop_en && sub_frame_odd) |=>
        (eff_quad == 2'($past(quad_number) + $past(hop_dealias.hop_offset)));
  endproperty
  a_hop_alt: assert property (p_hop_alt) else $error("de-aliasing hop offset");

  property p_tick_gap;
    @(posedge clock) disable iff (srst)
      (tick && pll_reg.pll_prescaler == 4'h1 && !(apply_d_reg && !pll_apply_pulse)) |=> !tick;
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("prescaler tick too fast");

endmodule : tmsc_mod_shutter

// ===== hdl/tmsc_pkg.sv
// types shared by the modulation and shutter control block
// assumes tmsc_map.svh supplies the numeric constants
package tmsc_pkg;

  // quad phases seen from the timing generator, one-hot
  typedef enum logic [3:0] {
    TMSC_Q_RESET   = 4'b0001,
    TMSC_Q_INTEG   = 4'b0010,
    TMSC_Q_READOUT = 4'b0100,
    TMSC_Q_DEAD    = 4'b1000
  } tmsc_quad_t;

  // pin and shutter configuration
  typedef struct packed {
    logic       shutter_en;
    logic       mod_hold;
    logic       pixel_dc_level;
    logic       light_dc_level;
    logic       light_driver_lead;
    logic       duty_trim_direction;
    logic [3:0] duty_trim_steps;
  } tmsc_cfg_t;

  // phase sequence per modulation frequency
  typedef struct packed {
    logic       hop_en;
    logic [1:0] hop_offset;
  } tmsc_hop_t;

  // modulation pll settings
  typedef struct packed {
    logic [7:0]  pll_multiplier;
    logic [15:0] pll_multiplier_fraction;
    logic [3:0]  pll_divider;
    logic [3:0]  pll_prescaler;
  } tmsc_pll_t;

endpackage : tmsc_pkg
